// ==== design/pciel_map.vh ====
// constants for the pci target endian lane mapper
//
// Functional notes
// - the pci side is always little-endian, whatever the local order
// - local order comes from the global order bit; big-endian after reset
// - image invert bit flips the global order for this channel only
// - big-endian local bus: swap lanes so every byte keeps its address
// - little-endian local bus: bytes keep their lanes, addresses translate
// - local width from image data width field; 16-bit and 8-bit ports
// - tri-byte, misaligned or sparse writes become single-byte writes
// - little-endian 32-bit writes: size 01/10/00, address counted from lane 3
// - little-endian byte and low halfword writes replicate onto upper lanes
// - big-endian low address comes from the lowest enabled byte
// - big-endian writes reverse words and halfwords, bytes replicate
// - 16-bit port: word splits into two halfwords, halfword and byte issued singly
// - 8-bit port: word gives four bytes, halfword two, byte unchanged
// - little-endian reads: same encoding, bytes from own lane, no copies
// - big-endian reads: offset 00 from lane 3, reversed back to pci
// - tri-byte, misaligned or sparse reads become single-byte reads
// - packing decided only from byte enables and port size
`ifndef PCIEL_MAP_VH
`define PCIEL_MAP_VH

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define PCIEL_AW            8
`define PCIEL_OFS_MISC      8'h00
`define PCIEL_OFS_IMAGE     8'h04
`define PCIEL_OFS_STATUS    8'h08
`define PCIEL_BIT_ORDER     0
`define PCIEL_RST_ORDER     1'b1
`define PCIEL_BIT_INVERT    2
`define PCIEL_RST_INVERT    1'b0
`define PCIEL_RST_WIDTH     2'b00
`define PCIEL_BIT_BUSY      0
`define PCIEL_BIT_CNT_LO    4

// ----------------------------------------------------------------------
// encodings
// ----------------------------------------------------------------------
`define PCIEL_WID_32        2'b00
`define PCIEL_WID_16        2'b01
`define PCIEL_WID_8         2'b10
`define PCIEL_SIZ_WORD      2'b00
`define PCIEL_SIZ_BYTE      2'b01
`define PCIEL_SIZ_HALF      2'b10
`define PCIEL_U_WHOLE       2'b00
`define PCIEL_U_HALF        2'b01
`define PCIEL_U_BYTE        2'b10

`endif

// ==== design/pciel_mapper.v ====
// request fifo and endian lane mapper for the pci target channel
`timescale 1ns/1ps
`default_nettype none
`include "pciel_map.vh"

// ----------------------------------------------------------------------
// request fifo
// ----------------------------------------------------------------------
module pciel_fifo #(
  parameter W     = 37,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire          CLK,
  input  wire          SRST,
  input  wire          IN_VALID,
  output wire          IN_READY,
  input  wire [W-1:0]  IN_DATA,
  output wire          OUT_VALID,
  input  wire          OUT_READY,
  output wire [W-1:0]  OUT_DATA,
  output wire [AW:0]   COUNT
);
  reg  [W-1:0]  mem [0:DEPTH-1];
  reg  [AW-1:0] wp_r;
  reg  [AW-1:0] rp_r;
  reg  [AW:0]   cnt_r;
  wire          push;
  wire          pop;

  // full and empty come straight from the count
  assign IN_READY  = (cnt_r != DEPTH[AW:0]);
  assign OUT_VALID = (cnt_r != {(AW+1){1'b0}});
  assign OUT_DATA  = mem[rp_r];
  assign COUNT     = cnt_r;
  assign push      = IN_VALID & IN_READY;
  assign pop       = OUT_VALID & OUT_READY;

  // pointers wrap at depth; depth need not be a power of two
  always @(posedge CLK) begin
    if (SRST) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
      end
      if (push & ~pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop & ~push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  // storage has no reset; only valid entries are ever read
  always @(posedge CLK) begin
    if (push) begin
      mem[wp_r] <= IN_DATA;
    end
  end
endmodule

// ----------------------------------------------------------------------
// mapper top
// ----------------------------------------------------------------------
module pciel_mapper #(
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW    = 2
) (
  input  wire                   CLK,
  input  wire                   SRST,
  input  wire                   PSEL,
  input  wire                   PENABLE,
  input  wire                   PWRITE,
  input  wire [`PCIEL_AW-1:0]   PADDR,
  input  wire [31:0]            PWDATA,
  output reg  [31:0]            PRDATA,
  output wire                   PREADY,
  output reg                    PSLVERR,
  input  wire                   PCI_REQ_VALID,
  output wire                   PCI_REQ_READY,
  input  wire                   PCI_REQ_WRITE,
  input  wire [3:0]             PCI_BE_N,
  input  wire [31:0]            PCI_WDATA,
  output reg                    PCI_DONE,
  output reg  [31:0]            PCI_RDATA,
  output wire                   LB_VALID,
  input  wire                   LB_READY,
  output reg                    LB_WRITE,
  output reg  [1:0]             LB_SIZE,
  output reg  [1:0]             LB_ADDR,
  output reg  [31:0]            LB_WDATA,
  input  wire [31:0]            LB_RDATA
);
  localparam S_IDLE  = 2'd0;
  localparam S_LOAD  = 2'd1;
  localparam S_ISSUE = 2'd2;
  localparam S_DONE  = 2'd3;

  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg         order_r;
  reg         invert_r;
  reg  [1:0]  width_r;
  reg         big_r;
  reg  [1:0]  unit_r;
  reg  [3:0]  rem_r;
  reg  [3:0]  cur_r;
  reg  [31:0] wdat_r;
  reg  [1:0]  unit_nxt;
  reg  [3:0]  sel;
  wire [36:0] fifo_out;
  wire        fifo_valid;
  wire        fifo_pop;
  wire [FIFO_AW:0] fifo_cnt;
  wire [3:0]  en;
  wire        is_word;
  wire        is_half;
  wire        is_byte;
  wire        apb_setup;
  wire        apb_wr;
  wire [31:0] rd_mapped;
  integer     i;

  // ----------------------------------------------------------------------
  // lane and address helpers
  // ----------------------------------------------------------------------
  function [31:0] bswap;
    input [31:0] d;
    begin
      bswap = {d[7:0], d[15:8], d[23:16], d[31:24]};
    end
  endfunction

  // index of the lowest enabled pci byte
  function [1:0] low_idx;
    input [3:0] m;
    begin
      casez (m)
        4'b???1: low_idx = 2'd0;
        4'b??10: low_idx = 2'd1;
        4'b?100: low_idx = 2'd2;
        default: low_idx = 2'd3;
      endcase
    end
  endfunction

  function [7:0] getb;
    input [31:0] d;
    input [1:0]  k;
    begin
      case (k)
        2'd0:    getb = d[7:0];
        2'd1:    getb = d[15:8];
        2'd2:    getb = d[23:16];
        default: getb = d[31:24];
      endcase
    end
  endfunction

  // transfer size from the number of bytes in one cycle
  function [1:0] size_of;
    input [3:0] m;
    begin
      if (m == 4'hf) begin
        size_of = `PCIEL_SIZ_WORD;
      end else if (m == 4'h3 || m == 4'hc) begin
        size_of = `PCIEL_SIZ_HALF;
      end else begin
        size_of = `PCIEL_SIZ_BYTE;
      end
    end
  endfunction

  // low local address of one cycle
  function [1:0] addr_of;
    input [3:0] m;
    input       big;
    begin
      if (big || m == 4'hf) begin
        addr_of = (m == 4'hf) ? 2'b00 : low_idx(m);
      end else if (size_of(m) == `PCIEL_SIZ_HALF) begin
        addr_of = 2'd2 - low_idx(m);
      end else begin
        addr_of = 2'd3 - low_idx(m);
      end
    end
  endfunction

  // write lane placement for one cycle, unused lanes driven low
  function [31:0] wmap;
    input [3:0]  m;
    input [31:0] d;
    input        big;
    reg   [7:0]  b;
    reg   [7:0]  hi;
    reg   [7:0]  lo;
    reg   [1:0]  a;
    begin
      b  = getb(d, low_idx(m));
      a  = addr_of(m, big);
      hi = big ? b : getb(d, low_idx(m) + 2'd1);
      lo = big ? getb(d, low_idx(m) + 2'd1) : b;
      if (size_of(m) == `PCIEL_SIZ_WORD) begin
        wmap = big ? bswap(d) : d;
      end else if (size_of(m) == `PCIEL_SIZ_HALF) begin
        // low halfword copied to both halves
        wmap = (a == 2'b10) ? {hi, lo, hi, lo} : {hi, lo, 16'h0000};
      end else begin
        // byte replication same in both orders
        case (a)
          2'b00:   wmap = {b, 24'h000000};
          2'b01:   wmap = {b, b, 16'h0000};
          2'b10:   wmap = {b, 8'h00, b, 8'h00};
          default: wmap = {b, b, 8'h00, b};
        endcase
      end
    end
  endfunction

  // next piece of the remaining bytes, lowest local address first
  function [3:0] pick;
    input [3:0] rem;
    input [1:0] unit;
    input       big;
    begin
      pick = rem;
      if (unit == `PCIEL_U_HALF) begin
        if (big) begin
          pick = (rem[1:0] != 2'b00) ? {2'b00, rem[1:0]} : {rem[3:2], 2'b00};
        end else begin
          pick = (rem[3:2] != 2'b00) ? {rem[3:2], 2'b00} : {2'b00, rem[1:0]};
        end
      end else if (unit == `PCIEL_U_BYTE) begin
        if (big) begin
          pick = rem & (~rem + 4'h1);
        end else if (rem[3]) begin
          pick = 4'h8;
        end else if (rem[2]) begin
          pick = 4'h4;
        end else if (rem[1]) begin
          pick = 4'h2;
        end else begin
          pick = 4'h1;
        end
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // request fifo
  // ----------------------------------------------------------------------
  pciel_fifo #(
    .W     (37),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .CLK       (CLK),
    .SRST      (SRST),
    .IN_VALID  (PCI_REQ_VALID),
    .IN_READY  (PCI_REQ_READY),
    .IN_DATA   ({PCI_REQ_WRITE, PCI_BE_N, PCI_WDATA}),
    .OUT_VALID (fifo_valid),
    .OUT_READY (fifo_pop),
    .OUT_DATA  (fifo_out),
    .COUNT     (fifo_cnt)
  );

  // fifo only drains while idle, so a busy local bus backs up pci
  assign fifo_pop = (state_r == S_IDLE);

  // ----------------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------------
  assign PREADY    = 1'b1;
  assign apb_setup = PSEL & ~PENABLE;
  assign apb_wr    = PSEL & PENABLE & PWRITE;

  // config writes; a transfer in flight keeps what it latched
  always @(posedge CLK) begin
    if (SRST) begin
      order_r  <= `PCIEL_RST_ORDER;
      invert_r <= `PCIEL_RST_INVERT;
      width_r  <= `PCIEL_RST_WIDTH;
    end else if (apb_wr) begin
      if (PADDR == `PCIEL_OFS_MISC) begin
        order_r <= PWDATA[`PCIEL_BIT_ORDER];
      end
      if (PADDR == `PCIEL_OFS_IMAGE) begin
        width_r  <= PWDATA[1:0];
        invert_r <= PWDATA[`PCIEL_BIT_INVERT];
      end
    end
  end

  // read data and error prepared in setup, shown in the access cycle
  always @(posedge CLK) begin
    if (SRST) begin
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else if (apb_setup) begin
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
      case (PADDR)
        `PCIEL_OFS_MISC:   PRDATA[`PCIEL_BIT_ORDER] <= order_r;
        `PCIEL_OFS_IMAGE:  PRDATA <= {29'h0, invert_r, width_r};
        `PCIEL_OFS_STATUS: begin
          PRDATA[`PCIEL_BIT_BUSY] <= (state_r != S_IDLE) | fifo_valid;
          PRDATA[`PCIEL_BIT_CNT_LO +: FIFO_AW+1] <= fifo_cnt;
        end
        default:           PSLVERR <= 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // transfer classification
  // ----------------------------------------------------------------------
  // pci byte enables are little-endian lanes
  assign en      = ~fifo_out[35:32];
  assign is_word = (en == 4'hf);
  assign is_half = (en == 4'h3) || (en == 4'hc);
  assign is_byte = (en == 4'h1) || (en == 4'h2) || (en == 4'h4) ||
                   (en == 4'h8);

  // split from enables and port size only
  always @* begin
    unit_nxt = `PCIEL_U_BYTE;
    case (width_r)
      `PCIEL_WID_8:  unit_nxt = `PCIEL_U_BYTE;
      `PCIEL_WID_16: unit_nxt = is_word ? `PCIEL_U_HALF :
                                (is_half | is_byte) ? `PCIEL_U_WHOLE :
                                `PCIEL_U_BYTE;
      default:       unit_nxt = (is_word | is_half | is_byte) ?
                                `PCIEL_U_WHOLE : `PCIEL_U_BYTE;
    endcase
  end

  always @* begin
    sel = pick(rem_r, unit_r, big_r);
  end

  // ----------------------------------------------------------------------
  // cycle sequencer
  // ----------------------------------------------------------------------
  assign LB_VALID = (state_r == S_ISSUE);

  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE:  if (fifo_valid) begin
                 state_nxt = (en == 4'h0) ? S_DONE : S_LOAD;
               end
      S_LOAD:  state_nxt = S_ISSUE;
      // pci finishes after the last cycle
      S_ISSUE: if (LB_READY) begin
                 state_nxt = (rem_r == 4'h0) ? S_DONE : S_LOAD;
               end
      S_DONE:  state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  // big-endian reads reverse, little-endian reads do not
  assign rd_mapped = big_r ? bswap(LB_RDATA) : LB_RDATA;

  always @(posedge CLK) begin
    if (SRST) begin
      state_r   <= S_IDLE;
      big_r     <= 1'b1;
      unit_r    <= `PCIEL_U_WHOLE;
      rem_r     <= 4'h0;
      cur_r     <= 4'h0;
      wdat_r    <= 32'h00000000;
      LB_WRITE  <= 1'b0;
      LB_SIZE   <= `PCIEL_SIZ_WORD;
      LB_ADDR   <= 2'b00;
      LB_WDATA  <= 32'h00000000;
      PCI_DONE  <= 1'b0;
      PCI_RDATA <= 32'h00000000;
    end else begin
      state_r  <= state_nxt;
      PCI_DONE <= (state_nxt == S_DONE);
      case (state_r)
        S_IDLE: if (fifo_valid) begin
          // image invert flips the global order
          big_r     <= order_r ^ invert_r;
          // port width sets the cycle split
          unit_r    <= unit_nxt;
          rem_r     <= en;
          wdat_r    <= fifo_out[31:0];
          LB_WRITE  <= fifo_out[36];
          PCI_RDATA <= 32'h00000000;
        end
        S_LOAD: begin
          cur_r    <= sel;
          rem_r    <= rem_r & ~sel;
          LB_SIZE  <= size_of(sel);
          LB_ADDR  <= addr_of(sel, big_r);
          // copies on other lanes are for the peripheral to ignore
          LB_WDATA <= wmap(sel, wdat_r, big_r);
        end
        S_ISSUE: if (LB_READY & ~LB_WRITE) begin
          // each single-byte read fills only its own lane
          for (i = 0; i < 4; i = i + 1) begin
            if (cur_r[i]) begin
              PCI_RDATA[8*i +: 8] <= rd_mapped[8*i +: 8];
            end
          end
        end
        default: begin
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== test/pciel_mapper_chk.sv ====
// assertion checker for the pci target endian lane mapper
`timescale 1ns/1ps
`default_nettype none
`include "pciel_map.vh"

// ----------------------------------------------------------------------
// local bus and completion properties
// ----------------------------------------------------------------------
module pciel_mapper_chk (
  input wire logic        CLK,
  input wire logic        SRST,
  input wire logic        PCI_DONE,
  input wire logic        LB_VALID,
  input wire logic        LB_READY,
  input wire logic        LB_WRITE,
  input wire logic [1:0]  LB_SIZE,
  input wire logic [1:0]  LB_ADDR,
  input wire logic [31:0] LB_WDATA
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  // top lane carries the byte for every byte cycle
  wire logic [7:0] top_b = LB_WDATA[31:24];

  hold_req_a : assert property (
    LB_VALID && !LB_READY |=> LB_VALID &&
      $stable({LB_WRITE, LB_SIZE, LB_ADDR, LB_WDATA}))
    else $error("local cycle changed before acceptance");
  lb_gap_a : assert property (
    LB_VALID && LB_READY |=> !LB_VALID)
    else $error("no idle cycle after local acceptance");
  done_pulse_a : assert property (
    PCI_DONE |=> !PCI_DONE)
    else $error("completion pulse longer than one cycle");
  size_code_a : assert property (
    LB_VALID |-> LB_SIZE != 2'b11)
    else $error("undefined transfer size code");
  word_addr_a : assert property (
    LB_VALID && LB_SIZE == `PCIEL_SIZ_WORD |-> LB_ADDR == 2'b00)
    else $error("word cycle with nonzero low address");
  half_addr_a : assert property (
    LB_VALID && LB_SIZE == `PCIEL_SIZ_HALF |-> !LB_ADDR[0])
    else $error("halfword cycle on odd address");
  byte_copy_a : assert property (
    LB_VALID && LB_WRITE && LB_SIZE == `PCIEL_SIZ_BYTE |->
      LB_WDATA[23:0] == {LB_ADDR[0] ? top_b : 8'h00,
      LB_ADDR == 2'b10 ? top_b : 8'h00, LB_ADDR == 2'b11 ? top_b : 8'h00})
    else $error("byte write lane copies wrong");
  half_copy_a : assert property (
    LB_VALID && LB_WRITE && LB_SIZE == `PCIEL_SIZ_HALF |->
      LB_WDATA[15:0] == (LB_ADDR[1] ? LB_WDATA[31:16] : 16'h0000))
    else $error("halfword write lane copies wrong");
endmodule

bind pciel_mapper pciel_mapper_chk u_pciel_mapper_chk (
  .CLK(CLK), .SRST(SRST), .PCI_DONE(PCI_DONE), .LB_VALID(LB_VALID),
  .LB_READY(LB_READY), .LB_WRITE(LB_WRITE), .LB_SIZE(LB_SIZE),
  .LB_ADDR(LB_ADDR), .LB_WDATA(LB_WDATA));
`default_nettype wire

// ==== test/pciel_lbus_model.sv ====
// behavioural local bus peripheral answering the mapper
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// local bus peripheral model
// ----------------------------------------------------------------------
module pciel_lbus_model (
  input  wire logic        CLK,
  input  wire logic        SRST,
  input  wire logic        LB_VALID,
  input  wire logic        LB_WRITE,
  input  wire logic        STALL,
  input  wire logic [31:0] RD_WORD,
  output wire logic        LB_READY,
  output wire logic [31:0] LB_RDATA
);
  logic [1:0]  cnt_r;
  logic [1:0]  lat_r;
  logic [31:0] junk_r;
  // read answers drive the whole RD_WORD on all four lanes
  // write data is never stored, so replicated lane copies are ignored
  assign LB_READY = LB_VALID && !STALL && cnt_r == lat_r;
  // outside an answer the bus shows a changing pattern, not old data
  assign LB_RDATA = (LB_READY && !LB_WRITE) ? RD_WORD : junk_r;
  // latency of 0 to 2 cycles, picked anew after every acceptance
  always @(posedge CLK) begin
    junk_r <= junk_r * 32'h0019660d + 32'h3c6ef35f;
    if (SRST) begin
      cnt_r <= 2'd0;
      lat_r <= 2'd0;
      junk_r <= 32'h1;
    end else if (LB_READY) begin
      cnt_r <= 2'd0;
      lat_r <= 2'($urandom % 3);
    end else if (LB_VALID && !STALL && cnt_r != lat_r) begin
      cnt_r <= cnt_r + 2'd1;
    end
  end
endmodule
`default_nettype wire

// ==== test/pciel_mapper_tb_top.sv ====
// self-checking testbench for the pci target endian lane mapper
`timescale 1ns/1ps
`default_nettype none
`include "pciel_map.vh"

// ----------------------------------------------------------------------
// bench top
// ----------------------------------------------------------------------
module pciel_mapper_tb_top;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, wdata, rdata, lb_wd, lb_rd, rd_word;
  logic        req_v, req_rdy, req_w, done, lb_v, lb_rdy, lb_w, stall;
  logic [3:0]  be_n;
  logic [1:0]  lb_size, lb_addr, wid;
  logic        big;
  logic [36:0] pq[$];
  logic [32:0] dq[$];
  logic [36:0] pe;
  logic [32:0] de;
  int          fails, n_tests;

  pciel_mapper u_pciel_mapper (.CLK(clk), .SRST(srst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PCI_REQ_VALID(req_v), .PCI_REQ_READY(req_rdy), .PCI_REQ_WRITE(req_w),
    .PCI_BE_N(be_n), .PCI_WDATA(wdata), .PCI_DONE(done), .PCI_RDATA(rdata),
    .LB_VALID(lb_v), .LB_READY(lb_rdy), .LB_WRITE(lb_w), .LB_SIZE(lb_size),
    .LB_ADDR(lb_addr), .LB_WDATA(lb_wd), .LB_RDATA(lb_rd));
  pciel_lbus_model u_pciel_lbus_model (.CLK(clk), .SRST(srst),
    .LB_VALID(lb_v), .LB_WRITE(lb_w), .STALL(stall), .RD_WORD(rd_word),
    .LB_READY(lb_rdy), .LB_RDATA(lb_rd));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("wrong value at %0t: seen %h, expected %h", $time, s, e);
    end
  endtask

  task conclude;
    if (fails == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  function automatic logic [31:0] swap(input logic [31:0] x);
    return {x[7:0], x[15:8], x[23:16], x[31:24]};
  endfunction

  function automatic logic [31:0] lanes(input logic [3:0] en);
    return {{8{en[3]}}, {8{en[2]}}, {8{en[1]}}, {8{en[0]}}};
  endfunction

  // apb transfer; pready decides when the access ends
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [31:0] e, input logic er);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // no wait-state count assumed; only the watchdog ends a hung wait
    while (pready !== 1'b1) @(posedge clk);
    chk(32'(pslverr), 32'(er));
    if (!w && !er) chk(prdata, e);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // expected local pieces
  // ascending local address: lowest pci byte first only when big-endian
  task plan(input logic w, input logic [3:0] en, input logic [31:0] d);
    int k;
    logic [1:0] a;
    logic [7:0] hi, lo;
    if (en == 4'hf && wid != `PCIEL_WID_16 && wid != `PCIEL_WID_8)
      pq.push_back({w, `PCIEL_SIZ_WORD, 2'b00, big ? swap(d) : d});
    else for (int i = 0; i < 4; i++) begin
      k = big ? i : 3 - i;
      if (wid != `PCIEL_WID_8 && (en == 4'hf || en == 4'h3 || en == 4'hc))
      begin
        if (k % 2 == 0 && en[k]) begin
          a = big ? 2'(k) : 2'(2 - k);
          hi = big ? d[8*k+:8] : d[8*k+8+:8];
          lo = big ? d[8*k+8+:8] : d[8*k+:8];
          pq.push_back({w, `PCIEL_SIZ_HALF, a, hi, lo,
                        a[1] ? {hi, lo} : 16'h0000});
        end
      end else if (en[k]) begin
        a = big ? 2'(k) : 2'(3 - k);
        lo = d[8*k+:8];
        pq.push_back({w, `PCIEL_SIZ_BYTE, a, lo, a[0] ? lo : 8'h00,
                      a == 2'd2 ? lo : 8'h00, a == 2'd3 ? lo : 8'h00});
      end
    end
  endtask

  // one pci transfer; notes are queued before the request is offered
  task pci(input logic w, input logic [3:0] en, input logic [31:0] d);
    plan(w, en, d);
    dq.push_back({~w, (big ? swap(rd_word) : rd_word) & lanes(en)});
    @(posedge clk);
    req_v <= 1'b1;
    req_w <= w;
    be_n <= ~en;
    wdata <= d;
    @(posedge clk);
    // request stands until the fifo takes it; never dropped unaccepted
    while (req_rdy !== 1'b1) @(posedge clk);
    req_v <= 1'b0;
  endtask

  task drain;
    for (int n = 0; n < 400 && pq.size() + dq.size() != 0; n++)
      @(posedge clk);
    repeat (3) @(posedge clk);
  endtask

  // watch local cycles and completions against the oldest notes
  always @(posedge clk) begin
    if (!srst && lb_v === 1'b1 && lb_rdy === 1'b1) begin
      if (pq.size() == 0) chk(32'h0, 32'h1);
      else begin
        pe = pq.pop_front();
        chk(32'({lb_w, lb_size, lb_addr}), 32'(pe[36:32]));
        if (pe[36]) chk(lb_wd, pe[31:0]);
      end
    end
    if (!srst && done === 1'b1) begin
      if (dq.size() == 0) chk(32'h0, 32'h1);
      else begin
        de = dq.pop_front();
        if (de[32]) chk(rdata, de[31:0]);
      end
    end
  end

  initial begin
    #200000;
    fails++;
    conclude();
  end

  initial begin
    void'($urandom(32'hc46f926f));
    {psel, penable, pwrite, req_v, req_w, stall} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    be_n = 4'hf;
    wdata = 32'h0;
    rd_word = 32'h0;
    srst = 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    apb(1'b0, `PCIEL_OFS_MISC, 32'h0, 32'h1, 1'b0);
    apb(1'b0, `PCIEL_OFS_IMAGE, 32'h0, 32'h0, 1'b0);
    apb(1'b1, `PCIEL_OFS_STATUS, 32'hff, 32'h0, 1'b0);
    apb(1'b0, `PCIEL_OFS_STATUS, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 8'h0c, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 8'h40, 32'hffffffff, 32'h0, 1'b1);
    // every order, invert, width and enable pattern
    for (int c = 0; c < 16; c++) begin
      big = c[0] ^ c[1];
      wid = c[3:2];
      apb(1'b1, `PCIEL_OFS_MISC, {31'h0, c[0]}, 32'h0, 1'b0);
      apb(1'b1, `PCIEL_OFS_IMAGE, {29'h0, c[1], c[3:2]}, 32'h0, 1'b0);
      apb(1'b0, `PCIEL_OFS_MISC, 32'h0, {31'h0, c[0]}, 1'b0);
      apb(1'b0, `PCIEL_OFS_IMAGE, 32'h0, {29'h0, c[1], c[3:2]}, 1'b0);
      rd_word = $urandom;
      for (int e = 0; e < 16; e++) begin
        pci(1'b1, 4'(e), $urandom);
        pci(1'b0, 4'(e), 32'h0);
      end
      drain();
    end
    // stalled far side fills the queue, then it drains in order
    stall <= 1'b1;
    repeat (5) pci(1'b1, 4'hf, $urandom);
    repeat (2) @(posedge clk);
    chk(32'(req_rdy), 32'h0);
    apb(1'b0, `PCIEL_OFS_STATUS, 32'h0, 32'h41, 1'b0);
    stall <= 1'b0;
    drain();
    chk(32'(pq.size() + dq.size()), 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
